// [pkg/pop_cfg.svh]
// Constants of the port one pin control block: offsets, layouts, resets.
// Assumes inclusion by the package, the design file and the testbench.
`ifndef POP_CFG_SVH
`define POP_CFG_SVH

// ----------------------------------------------------------------------
// Register indices; byte address is four times the index.
// ----------------------------------------------------------------------
`define POP_IDX_DATA 16'hFFD4
`define POP_IDX_DIR 16'hFFE4
`define POP_IDX_PULL 16'hFFED
`define POP_IDX_FUNC 16'hFFFC
`define POP_IDX_EDGE 16'hFF00
`define POP_IDX_PWR 16'hFF01

// ----------------------------------------------------------------------
// Reset values and bit layouts.
// ----------------------------------------------------------------------
`define POP_RST_DATA 8'h00
`define POP_RST_DIR 8'h00
`define POP_RST_PULL 8'h00
`define POP_RST_FUNC 8'h04
`define POP_RST_EDGE 8'h00
`define POP_PIN_MASK 8'hF1
`define POP_FUNC_FIXED 8'h04
`define POP_DIR_READ 8'hFF
`define POP_BIT_EXT_INTERRUPT_THREE_SELECT 7
`define POP_BIT_EXT_INTERRUPT_TWO_SELECT 6
`define POP_BIT_EXT_INTERRUPT_ONE_SELECT 5
`define POP_BIT_PWM 4
`define POP_BIT_TIMER_OUTPUT_SELECT 0
`define POP_EDGE_TRG_LSB 4
`define POP_PWR_W 3

`endif

// [pkg/pop_pkg.sv]
// Types of the port one pin control block.
// Assumes pop_cfg.svh on the include path.
package pop_pkg;
   `include "pop_cfg.svh"

   typedef enum logic [3:0] {
      POP_BUS_IDLE = 4'h1,
      POP_BUS_WR = 4'h2,
      POP_BUS_RDW = 4'h4,
      POP_BUS_RDD = 4'h8
   } pop_bus_t;

   typedef enum logic [2:0] {
      POP_PWR_ACTIVE = 3'h0,
      POP_PWR_SLEEP = 3'h1,
      POP_PWR_STANDBY = 3'h2,
      POP_PWR_WATCH = 3'h3,
      POP_PWR_SUBACT = 3'h4,
      POP_PWR_SUBSLEEP = 3'h5
   } pop_pwr_t;

   typedef enum logic [1:0] {
      POP_TRG_FALL = 2'h0,
      POP_TRG_RISE = 2'h1,
      POP_TRG_BOTH = 2'h2
   } pop_trg_t;
endpackage

// [verilog/pop_port_one.sv]
// Port one pin control: five pins (7..4, 0), pull-ups, alternate functions.
// Assumes one AHB-Lite master, pins synchronous to hclk, and a pad cell
// that resolves the pin from pin_out, pin_oe and pull_en.
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`include "pop_cfg.svh"
module pop_port_one
   import pop_pkg::*;
(
   // Clock, reset, enable.
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Pins.
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   output logic [7:0] pull_en,
   // Peripheral side.
   input wire logic pwm_in,
   input wire logic timer_in,
   output logic [3:1] ext_irq,
   output logic timer_trigger_input
);

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   function automatic logic hits(input logic [31:0] a, input logic [15:0] idx);
      hits = (a[31:18] == 14'h0000) && (a[17:0] == {idx, 2'b00});
   endfunction

   function automatic logic edge_seen(input logic prev, input logic now,
                                      input logic rise);
      edge_seen = rise ? (!prev && now) : (prev && !now);
   endfunction

   // -------------------------------------------------------------------
   // Registers and bus state
   // -------------------------------------------------------------------
   logic [7:0] output_data_reg;
   logic [7:0] direction_reg;
   logic [7:0] pullup_enable_reg;
   logic [7:0] pin_function_select_reg;
   logic [7:0] edge_cfg;
   pop_pwr_t power_mode;
   pop_bus_t bus_state;
   pop_bus_t next_bus_state;
   logic [31:0] addr_q;
   logic [7:0] prev_in;
   logic [7:0] read_port;
   logic [7:0] next_out;
   logic [7:0] next_oe;
   logic [7:0] next_pull;
   logic [31:0] next_rdata;
   logic take;
   logic wr_now;
   logic [7:0] wbyte;
   logic ext_interrupt_three_select;
   logic ext_interrupt_two_select;
   logic ext_interrupt_one_select;
   logic pwm_select;
   logic timer_output_select;
   logic hold_state;
   logic float_state;

   assign take = hsel && hready && htrans[1];
   assign wr_now = ce && (bus_state == POP_BUS_WR);
   assign wbyte = hwdata[7:0];
   assign ext_interrupt_three_select = pin_function_select_reg[`POP_BIT_EXT_INTERRUPT_THREE_SELECT];
   assign ext_interrupt_two_select = pin_function_select_reg[`POP_BIT_EXT_INTERRUPT_TWO_SELECT];
   assign ext_interrupt_one_select = pin_function_select_reg[`POP_BIT_EXT_INTERRUPT_ONE_SELECT];
   assign pwm_select = pin_function_select_reg[`POP_BIT_PWM];
   assign timer_output_select = pin_function_select_reg[`POP_BIT_TIMER_OUTPUT_SELECT];
   assign hold_state = (power_mode == POP_PWR_SLEEP) || (power_mode == POP_PWR_SUBSLEEP)
                       || (power_mode == POP_PWR_WATCH);
   assign float_state = (power_mode == POP_PWR_STANDBY);

   // -------------------------------------------------------------------
   // Bus sequencing
   // -------------------------------------------------------------------
   // Reads take one wait state so that a read right after a write sees it.
   always_comb begin
      next_bus_state = bus_state;
      unique case (bus_state)
         POP_BUS_IDLE,
         POP_BUS_WR,
         POP_BUS_RDD: begin
            if (take) begin
               next_bus_state = hwrite ? POP_BUS_WR : POP_BUS_RDW;
            end else begin
               next_bus_state = POP_BUS_IDLE;
            end
         end
         POP_BUS_RDW: begin
            next_bus_state = POP_BUS_RDD;
         end
         default: begin
            next_bus_state = POP_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_state <= POP_BUS_IDLE;
         addr_q <= 32'h0000_0000;
      end else if (ce) begin
         bus_state <= next_bus_state;
         if (take && (bus_state != POP_BUS_RDW)) begin
            addr_q <= haddr;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (ce) begin
         hreadyout <= (next_bus_state != POP_BUS_RDW);
         hresp <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Register writes
   // -------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         output_data_reg <= `POP_RST_DATA;
         direction_reg <= `POP_RST_DIR;
      end else if (wr_now) begin
         if (hits(addr_q, `POP_IDX_DATA)) begin
            output_data_reg <= wbyte & `POP_PIN_MASK;
         end
         if (hits(addr_q, `POP_IDX_DIR)) begin
            direction_reg <= wbyte & `POP_PIN_MASK;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pullup_enable_reg <= `POP_RST_PULL;
      end else if (wr_now && hits(addr_q, `POP_IDX_PULL)) begin
         pullup_enable_reg <= wbyte & `POP_PIN_MASK;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_function_select_reg <= `POP_RST_FUNC;
      end else if (wr_now && hits(addr_q, `POP_IDX_FUNC)) begin
         pin_function_select_reg <= (wbyte & `POP_PIN_MASK) | `POP_FUNC_FIXED;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         edge_cfg <= `POP_RST_EDGE;
         power_mode <= POP_PWR_ACTIVE;
      end else if (wr_now) begin
         if (hits(addr_q, `POP_IDX_EDGE)) begin
            edge_cfg <= {2'b00, wbyte[5:4], 1'b0, wbyte[2:0]};
         end
         if (hits(addr_q, `POP_IDX_PWR)) begin
            power_mode <= pop_pwr_t'(wbyte[`POP_PWR_W-1:0]);
         end
      end
   end

   // -------------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------------
   // mixed port read
   assign read_port = ((direction_reg & output_data_reg)
                      | (~direction_reg & pin_in)) & `POP_PIN_MASK;

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (hits(addr_q, `POP_IDX_DATA)) begin
         next_rdata = {24'h000000, read_port};
      end else if (hits(addr_q, `POP_IDX_DIR)) begin
         next_rdata = {24'h000000, `POP_DIR_READ};
      end else if (hits(addr_q, `POP_IDX_PULL)) begin
         next_rdata = {24'h000000, pullup_enable_reg};
      end else if (hits(addr_q, `POP_IDX_FUNC)) begin
         next_rdata = {24'h000000, pin_function_select_reg};
      end else if (hits(addr_q, `POP_IDX_EDGE)) begin
         next_rdata = {24'h000000, edge_cfg};
      end else if (hits(addr_q, `POP_IDX_PWR)) begin
         next_rdata = {29'h00000000, power_mode};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (ce) begin
         if (bus_state == POP_BUS_RDW) begin
            hrdata <= next_rdata;
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   // -------------------------------------------------------------------
   // Pin drive
   // -------------------------------------------------------------------
   always_comb begin
      next_oe = direction_reg & `POP_PIN_MASK;
      next_out = output_data_reg & `POP_PIN_MASK;
      next_pull = ~direction_reg & pullup_enable_reg & `POP_PIN_MASK;
      // input functions
      // Interrupt inputs keep the pull-up while their direction bit is clear, so an open line idles high.
      if (ext_interrupt_three_select) begin
         next_oe[7] = 1'b0;
         next_out[7] = 1'b0;
      end
      if (ext_interrupt_two_select) begin
         next_oe[6] = 1'b0;
         next_out[6] = 1'b0;
      end
      if (ext_interrupt_one_select) begin
         next_oe[5] = 1'b0;
         next_out[5] = 1'b0;
      end
      if (pwm_select) begin
         next_oe[4] = 1'b1;
         next_out[4] = pwm_in;
         next_pull[4] = 1'b0;
      end
      if (timer_output_select) begin
         next_oe[0] = 1'b1;
         next_out[0] = timer_in;
         next_pull[0] = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out <= 8'h00;
         pin_oe <= 8'h00;
         pull_en <= 8'h00;
      end else if (ce) begin
         if (float_state) begin
            pin_out <= 8'h00;
            pin_oe <= 8'h00;
            pull_en <= next_pull;
         end else if (!hold_state) begin
            pin_out <= next_out;
            pin_oe <= next_oe;
            pull_en <= next_pull;
         end
      end
   end

   // -------------------------------------------------------------------
   // Edge detection
   // -------------------------------------------------------------------
   // Edges are only looked for while the pin is given to the function, so
   // that general I/O traffic never raises a spurious request.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_in <= 8'h00;
         ext_irq <= 3'h0;
         timer_trigger_input <= 1'b0;
      end else if (ce) begin
         prev_in <= pin_in;
         ext_irq[3] <= ext_interrupt_three_select
                       && edge_seen(prev_in[7], pin_in[7], edge_cfg[2]);
         ext_irq[2] <= ext_interrupt_two_select
                       && edge_seen(prev_in[6], pin_in[6], edge_cfg[1]);
         ext_irq[1] <= ext_interrupt_one_select
                       && edge_seen(prev_in[5], pin_in[5], edge_cfg[0]);
         timer_trigger_input <= ext_interrupt_three_select
            && (edge_cfg[`POP_EDGE_TRG_LSB+1] ? (prev_in[7] != pin_in[7])
            : edge_seen(prev_in[7], pin_in[7], edge_cfg[`POP_EDGE_TRG_LSB]));
      end
   end

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_PULL_RSVD: assert property (pullup_enable_reg[3:1] == 3'h0)
      else $error("pull-up reserved bits not zero");
   AST_PULL_GATE: assert property (ce && !hold_state |=>
      (pull_en & ~$past(pullup_enable_reg & ~direction_reg)) == 8'h00
      && (pull_en & pin_oe) == 8'h00)
      else $error("pull-up on without its enable or on a driven pin");
   AST_PULL_ON: assert property (ce && !hold_state |=>
      ((pull_en ^ $past(pullup_enable_reg & ~direction_reg))
      & {3'h7, !$past(pwm_select), 3'h0, !$past(timer_output_select)}) == 8'h00)
      else $error("pull-up not following its enable");
   AST_PULL_RST: assert property ($rose(hresetn) |-> pullup_enable_reg == 8'h00)
      else $error("pull-up register not cleared by reset");
   AST_FUNC_RST: assert property ($rose(hresetn) |-> pin_function_select_reg == 8'h04)
      else $error("function register reset value wrong");
   AST_IRQ_INPUT: assert property (ce && !float_state && !hold_state
      && pin_function_select_reg[7:5] != 3'h0 |=>
      (pin_oe[7:5] & $past(pin_function_select_reg[7:5])) == 3'h0)
      else $error("interrupt pin driven");
   AST_PWM_DRIVE: assert property (ce && pwm_select && !float_state && !hold_state
      |=> pin_oe[4] && pin_out[4] == $past(pwm_in))
      else $error("pwm pin not following pwm output");
   AST_TIMER_OUTPUT_SELECT_DRIVE: assert property (ce && timer_output_select && !float_state
      && !hold_state |=> pin_oe[0] && pin_out[0] == $past(timer_in))
      else $error("timer output pin not following timer");
   AST_FUNC_RSVD: assert property (pin_function_select_reg[3:1] == 3'h2)
      else $error("function reserved bits wrong");
   AST_STANDBY: assert property (ce && float_state |=> pin_oe == 8'h00)
      else $error("pin driven in standby");
   AST_HOLD: assert property (ce && hold_state |=> $stable(pin_oe) && $stable(pin_out))
      else $error("pin changed while holding");
   AST_IRQ_EDGE: assert property (ce && ext_interrupt_two_select && edge_cfg[1]
      && !prev_in[6] && pin_in[6] |=> ext_irq[2])
      else $error("rising edge on interrupt two missed");
   AST_TRG_BOTH: assert property (ce && ext_interrupt_three_select
      && edge_cfg[5] && prev_in[7] != pin_in[7] |=> timer_trigger_input)
      else $error("trigger edge missed in both-edge mode");
   AST_READ_LAT: assert property (take && !hwrite && ce && bus_state != POP_BUS_RDW
      |=> !hreadyout ##1 hreadyout)
      else $error("read answer timing wrong");

   CVR_PWM: cover property (pwm_select && pin_oe[4]);
   CVR_IRQ: cover property (ext_irq[3]);
   CVR_READ: cover property (bus_state == POP_BUS_RDD && hits(addr_q, `POP_IDX_DATA));
   CVR_STANDBY_PULL: cover property (float_state && pull_en != 8'h00);

endmodule

// [dv/pop_pin_model.sv]
// Behavioural model of the pads and the board around port one.
// Assumes the design drives pin_out, pin_oe and pull_en synchronous to clk.
module pop_pin_model (
   // Clock.
   input wire logic clk,
   // Design side.
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pull_en,
   // Board side.
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   output logic [7:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [7:0] last;

   // ----------------------------------------------------------------------
   // Pad resolution
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      last <= pin_in;
   end

   // A floating pin shows the inverse of its last level, so that a read
   // of an undriven pin can never match by luck.
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i] === 1'b1) begin
            pin_in[i] = pin_out[i];
         end else if (ext_en[i] === 1'b1) begin
            pin_in[i] = ext_val[i];
         end else if (pull_en[i] === 1'b1) begin
            pin_in[i] = 1'b1;
         end else begin
            pin_in[i] = (last[i] !== 1'b1);
         end
      end
   end
endmodule

// [dv/testbench.sv]
// Self-checking testbench for the port one pin control block.
// Assumes pop_cfg.svh on the include path and pop_pkg compiled first.
`include "pop_cfg.svh"
module testbench
   import pop_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------------
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic pwm_in = 1'b0;
   logic timer_in = 1'b0;
   logic [7:0] ext_val = 8'h31;
   logic [7:0] ext_en = 8'hF1;
   logic hreadyout, hresp;
   logic [31:0] hrdata;
   logic [7:0] pin_in, pin_out, pin_oe, pull_en;
   logic [3:1] ext_irq;
   logic trg;
   logic [7:0] irq_cnt [3:1];
   logic [7:0] trg_cnt;
   logic [1:0] m;
   logic pol;
   logic ce = 1'b1;
   pop_pwr_t hold_md [3] = '{POP_PWR_SLEEP, POP_PWR_WATCH, POP_PWR_SUBSLEEP};
   int compares = 0;
   int miscompares = 0;

   always #50 hclk = ~hclk;

   pop_port_one i_pop_port_one (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en),
      .pwm_in(pwm_in), .timer_in(timer_in), .ext_irq(ext_irq), .timer_trigger_input(trg));

   pop_pin_model i_pop_pin_model (.clk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pull_en(pull_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

   // Pulses last one cycle, so they are counted rather than sampled.
   always @(posedge hclk) begin
      for (int i = 1; i < 4; i++) begin
         if (ext_irq[i] === 1'b1) begin
            irq_cnt[i] <= irq_cnt[i] + 8'h01;
         end
      end
      if (trg === 1'b1) begin
         trg_cnt <= trg_cnt + 8'h01;
      end
   end

   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   function automatic logic [31:0] ba(input logic [15:0] idx);
      return {14'h0, idx, 2'b00};
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, hreadyout, 1'b1);
      end
   endtask

   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= 1'b1;
      haddr <= ba(idx);
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wait_rdy();
   endtask

   task automatic rc(input logic [15:0] idx, input logic [7:0] exp);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= 1'b0;
      haddr <= ba(idx);
      wait_rdy();
      htrans <= 2'h0;
      wait_rdy();
      chk(hrdata[7:0], exp);
      chk({7'h0, hresp}, 8'h00);
   endtask

   task automatic finish_test;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------------
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(pin_oe, 8'h00);
      rc(`POP_IDX_PULL, 8'h00);
      rc(`POP_IDX_FUNC, 8'h04);
      rc(`POP_IDX_DIR, 8'hFF);
      rc(`POP_IDX_DATA, 8'h31);
      rc(16'h0010, 8'h00);
      wr(`POP_IDX_PULL, 8'hFF);
      rc(`POP_IDX_PULL, 8'hF1);
      tick(2);
      chk(pull_en, 8'hF1);
      wr(`POP_IDX_FUNC, 8'h00);
      rc(`POP_IDX_FUNC, 8'h04);
      wr(`POP_IDX_FUNC, 8'hFF);
      rc(`POP_IDX_FUNC, 8'hF5);
      wr(`POP_IDX_FUNC, 8'h00);
      ext_en <= 8'h01;
      wr(`POP_IDX_DIR, 8'hF0);
      wr(`POP_IDX_DATA, 8'hA0);
      tick(2);
      chk(pull_en, 8'h01);
      chk(pin_oe, 8'hF0);
      chk(pin_out & 8'hF0, 8'hA0);
      rc(`POP_IDX_DATA, 8'hA1);
      wr(`POP_IDX_PWR, {5'h0, POP_PWR_STANDBY});
      tick(2);
      chk(pin_oe, 8'h00);
      chk(pull_en, 8'h01);
      wr(`POP_IDX_PWR, {5'h0, POP_PWR_ACTIVE});
      // Each holding mode freezes the pins; subactive works like active.
      for (int j = 0; j < 3; j++) begin
         wr(`POP_IDX_PWR, {5'h0, hold_md[j]});
         wr(`POP_IDX_DATA, 8'h50);
         tick(2);
         chk(pin_out & 8'hF0, 8'hA0);
         wr(`POP_IDX_PWR, {5'h0, (j == 1) ? POP_PWR_SUBACT : POP_PWR_ACTIVE});
         tick(2);
         chk(pin_out & 8'hF0, 8'h50);
         wr(`POP_IDX_DATA, 8'hA0);
         tick(2);
      end
      // Alternate outputs with every direction bit at input.
      ext_en <= 8'h00;
      wr(`POP_IDX_DIR, 8'h00);
      pwm_in <= 1'b1;
      timer_in <= 1'b1;
      wr(`POP_IDX_FUNC, 8'h11);
      tick(2);
      chk(pin_oe & 8'h11, 8'h11);
      chk(pin_out & 8'h11, 8'h11);
      pwm_in <= 1'b0;
      tick(2);
      chk(pin_out & 8'h11, 8'h01);
      // With the clock enable low the pins must not follow the PWM.
      ce <= 1'b0;
      pwm_in <= 1'b1;
      tick(3);
      chk(pin_out & 8'h11, 8'h01);
      ce <= 1'b1;
      tick(2);
      chk(pin_out & 8'h11, 8'h11);
      // Edge detection on pins 7 to 5 for every trigger mode.
      ext_val <= 8'h00;
      ext_en <= 8'hE0;
      wr(`POP_IDX_FUNC, 8'hE0);
      wr(`POP_IDX_DIR, 8'hE0);
      tick(2);
      chk(pin_oe & 8'hE0, 8'h00);
      for (int k = 0; k < 3; k++) begin
         m = k[1:0];
         pol = (k == 1);
         wr(`POP_IDX_EDGE, {2'b00, m, 1'b0, {3{pol}}});
         irq_cnt <= '{8'h00, 8'h00, 8'h00};
         trg_cnt <= 8'h00;
         ext_val <= 8'hE0;
         tick(4);
         chk(irq_cnt[3], {7'h0, pol});
         chk(irq_cnt[2], {7'h0, pol});
         chk(irq_cnt[1], {7'h0, pol});
         chk(trg_cnt, {7'h0, m != POP_TRG_FALL});
         ext_val <= 8'h00;
         tick(4);
         chk(irq_cnt[3], 8'h01);
         chk(irq_cnt[2], 8'h01);
         chk(irq_cnt[1], 8'h01);
         chk(trg_cnt, (m == POP_TRG_BOTH) ? 8'h02 : 8'h01);
      end
      // General I/O inputs: edges reach the pins but must go unseen.
      wr(`POP_IDX_DIR, 8'h00);
      wr(`POP_IDX_FUNC, 8'h00);
      irq_cnt <= '{8'h00, 8'h00, 8'h00};
      trg_cnt <= 8'h00;
      ext_val <= 8'hE0;
      tick(4);
      chk(irq_cnt[3] | irq_cnt[2] | irq_cnt[1] | trg_cnt, 8'h00);
      // Reset in mid-run, with pins driven and registers loaded.
      wr(`POP_IDX_DIR, 8'hF1);
      wr(`POP_IDX_FUNC, 8'h10);
      tick(2);
      chk(pin_oe, 8'hF1);
      hresetn <= 1'b0;
      tick(2);
      chk(pin_oe, 8'h00);
      hresetn <= 1'b1;
      tick(1);
      rc(`POP_IDX_PULL, 8'h00);
      rc(`POP_IDX_FUNC, 8'h04);
      finish_test();
   end

   // Tests need well under a thousand cycles; this only cuts a hang short.
   initial begin
      repeat (5000) @(posedge hclk);
      miscompares++;
      finish_test();
   end
endmodule
